// ===== rtl/cpf_pkg.sv
package cpf_pkg;

    // Clock and derived timing counts.
    localparam int CLK_PERIOD_NS = 50;
    // A timeout is a least time, so it rounds up.
    localparam int TXDT_TIME_NS = 1000000;
    localparam int TXDT_CYC = (TXDT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Delay from a clear of the timeout flag to the return to normal mode.
    localparam int RECOVER_TIME_NS = 1000;
    localparam int RECOVER_CYC = (RECOVER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Delay before the timeout flag sets again after a failed clear.
    localparam int RETRIG_TIME_NS = 4000;
    localparam int RETRIG_CYC = (RETRIG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Least dominant and recessive length of one wake-up event.
    localparam int WAKE_PULSE_NS = 1000;
    localparam int WAKE_PULSE_CYC = (WAKE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Wake filter field encodings.
    localparam logic [1:0] WAKE_OFF = 2'h0;
    localparam logic [1:0] WAKE_MASK1 = 2'h1;
    localparam logic [1:0] WAKE_PASS = 2'h2;
    localparam logic [1:0] WAKE_MASK2 = 2'h3;

    // Bus levels and reset values.
    localparam logic RX_RECESSIVE = 1'b1;
    localparam logic [6:0] SYNC_RST = 7'h01;

    // Voltage comparator and status bits, one per line and threshold.
    typedef struct packed {
        logic hvh;
        logic hvl;
        logic lvh;
        logic lvl;
    } cpf_volt_type;

    // Fault interrupt flags.
    typedef struct packed {
        logic hvh;
        logic hvl;
        logic lvh;
        logic lvl;
        logic tdt;
        logic hoc;
        logic loc;
    } cpf_flags_type;

    // Interrupt enable bits.
    typedef struct packed {
        logic volt_fail;
        logic timeout;
        logic overcurrent;
    } cpf_irq_en_type;

    localparam cpf_volt_type VOLT_RST = '0;
    localparam cpf_flags_type FLAGS_RST = '0;

    typedef enum {ST_SHUTDOWN, ST_ACTIVE, ST_STANDBY} cpf_state_type;
    typedef enum {TO_IDLE, TO_FAULT, TO_RETRY, TO_RECOVER} cpf_to_type;
    typedef enum {WK_IDLE, WK_DOM, WK_REC} cpf_wake_type;
    typedef enum {OP_SHUTDOWN, OP_NORMAL, OP_PSEUDO, OP_LISTEN, OP_STANDBY} cpf_mode_type;

endpackage

// ===== rtl/cpf_top.sv
`timescale 1ns/10ps
// Functional notes
// - All fault interrupt sources are ORed into one interrupt output.
// - Four voltage flags raise the interrupt only with voltage enable set.
// - Timeout flag raises the interrupt only with its own enable set.
// - Both over-current flags raise the interrupt only with their enable set.
// - Comparator error sets status; any status change sets its flag.
// - Voltage status follows the comparators and clears when the fault ends.
// - Long dominant transmit gives listen-only, released bus, status and flag.
// - Clearing during dominant or active status keeps listen-only and resets flag.
// - Voltage-high or over-current forces listen-only, whole transmitter off, at once.
// - Driver off while any voltage-high status; back on automatically after.
// - Low-line voltage-low disables only the low-line driver.
// - Over-current seen only while driving dominant; shutdown latched until cleared.
// - In stop mode a nonzero wake field passes bus states to receive output.
// - Code 10 transparent, 01 masks first event, 11 masks first two.
// - Wake filter acts only after stop entry, not before.
// - Start in shutdown with monitors off; shutdown returns only by reset.
// - Receive output held recessive until the chosen event count is seen.
// - In standby the timeout counter stops and monitors are off.
// - Low-line voltage-low pseudo-normal returns to normal when the fault ends.
module cpf_top #(
    parameter int TXDT_CYC = cpf_pkg::TXDT_CYC
) (
    // Clock and reset.
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    // Software control.
    input wire logic phy_enable_i,
    input wire logic reduced_performance_mode_i,
    input wire logic stop_mode_i,
    input wire logic [1:0] wake_filter_select_i,
    input wire cpf_pkg::cpf_irq_en_type irq_enable_i,
    input wire cpf_pkg::cpf_flags_type flag_clear_i,
    // Analog comparators and receiver, asynchronous.
    input wire cpf_pkg::cpf_volt_type volt_cmp_i,
    input wire logic hi_oc_cmp_i,
    input wire logic lo_oc_cmp_i,
    input wire logic bus_rx_i,
    // Protocol controller side.
    input wire logic phy_tx_in_i,
    output logic phy_rx_out_o,
    // Status and driver control.
    output logic phy_irq_out_o,
    output cpf_pkg::cpf_flags_type flags_o,
    output cpf_pkg::cpf_volt_type status_o,
    output logic tx_dominant_timeout_status_o,
    output logic drive_hi_en_o,
    output logic drive_lo_en_o,
    output cpf_pkg::cpf_mode_type mode_o
);

    // One counter serves timeout, retrigger and recovery, so it must hold the longest of them.
    localparam int CNT_MAX = (TXDT_CYC > cpf_pkg::RETRIG_CYC) ? TXDT_CYC : cpf_pkg::RETRIG_CYC;
    localparam int CNT_W = $clog2(CNT_MAX + 1);
    localparam int WK_W = $clog2(cpf_pkg::WAKE_PULSE_CYC + 1);
    localparam int RETRIG_D = cpf_pkg::RETRIG_CYC + 1;
    localparam int REC_HI = 2 * cpf_pkg::RECOVER_CYC;

    // Masked event count for a wake field setting.
    function automatic logic [1:0] mask_count(input logic [1:0] sel);
        case (sel)
            cpf_pkg::WAKE_MASK1: mask_count = 2'h1;
            cpf_pkg::WAKE_MASK2: mask_count = 2'h2;
            default: mask_count = 2'h0;
        endcase
    endfunction

    // Reset release through two flops so all logic leaves reset on one edge.
    logic rst_meta_r;
    logic rst_n;
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_meta_r <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n <= rst_meta_r;
        end
    end

    // Two-flop synchronisers for all analog inputs.
    logic [6:0] sync1_r;
    logic [6:0] sync2_r;
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            sync1_r <= cpf_pkg::SYNC_RST;
            sync2_r <= cpf_pkg::SYNC_RST;
        end else begin
            sync1_r <= {volt_cmp_i, hi_oc_cmp_i, lo_oc_cmp_i, bus_rx_i};
            sync2_r <= sync1_r;
        end
    end

    cpf_pkg::cpf_volt_type volt_now;
    logic hoc_now;
    logic loc_now;
    logic rx_now;
    logic tx_dom;
    assign volt_now = cpf_pkg::cpf_volt_type'(sync2_r[6:3]);
    assign hoc_now = sync2_r[2];
    assign loc_now = sync2_r[1];
    assign rx_now = sync2_r[0];
    assign tx_dom = ~phy_tx_in_i;

    // State of the fault and mode logic.
    cpf_pkg::cpf_state_type st_r, st_nxt;
    cpf_pkg::cpf_to_type to_r, to_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    cpf_pkg::cpf_volt_type stat_r, stat_nxt;
    logic tdt_stat_r, tdt_stat_nxt;
    cpf_pkg::cpf_flags_type flags_r, flags_nxt;
    cpf_pkg::cpf_flags_type set_v;
    logic irq_r, irq_nxt;
    logic drv_hi_r, drv_hi_nxt;
    logic drv_lo_r, drv_lo_nxt;
    cpf_pkg::cpf_mode_type mode_r, mode_nxt;
    logic mon_on;
    logic listen;
    logic tdt_clear;
    logic irq_src;

    assign mon_on = (st_r == cpf_pkg::ST_ACTIVE);
    // Write-one clear, honoured only for a flag that is set.
    assign tdt_clear = flag_clear_i.tdt & flags_r.tdt;
    // Only voltage-high, over-current and the timeout stop the transmitter.
    assign listen = stat_r.hvh | stat_r.lvh | flags_r.hoc | flags_r.loc
                  | (to_r != cpf_pkg::TO_IDLE);
    assign irq_src = (irq_enable_i.volt_fail & (flags_r.hvh | flags_r.hvl
                   | flags_r.lvh | flags_r.lvl))
                   | (irq_enable_i.timeout & flags_r.tdt)
                   | (irq_enable_i.overcurrent & (flags_r.hoc | flags_r.loc));

    // Next values of mode, monitors, timeout, flags and drivers.
    always_comb begin
        st_nxt = st_r;
        to_nxt = to_r;
        cnt_nxt = cnt_r;
        stat_nxt = stat_r;
        tdt_stat_nxt = tdt_stat_r;
        set_v = cpf_pkg::FLAGS_RST;
        // Shutdown is left once and never re-entered short of reset.
        case (st_r)
            cpf_pkg::ST_SHUTDOWN: if (phy_enable_i) st_nxt = cpf_pkg::ST_ACTIVE;
            cpf_pkg::ST_ACTIVE: begin
                if (reduced_performance_mode_i) st_nxt = cpf_pkg::ST_STANDBY;
            end
            cpf_pkg::ST_STANDBY: begin
                if (!reduced_performance_mode_i) st_nxt = cpf_pkg::ST_ACTIVE;
            end
            default: st_nxt = cpf_pkg::ST_SHUTDOWN;
        endcase
        // Monitors are frozen outside the active state.
        if (mon_on) begin
            stat_nxt = volt_now;
            set_v.hvh = volt_now.hvh ^ stat_r.hvh;
            set_v.hvl = volt_now.hvl ^ stat_r.hvl;
            set_v.lvh = volt_now.lvh ^ stat_r.lvh;
            set_v.lvl = volt_now.lvl ^ stat_r.lvl;
            set_v.hoc = hoc_now & tx_dom & drv_hi_r;
            set_v.loc = loc_now & tx_dom & drv_lo_r;
        end
        if (!tx_dom) tdt_stat_nxt = 1'b0;
        case (to_r)
            cpf_pkg::TO_IDLE: begin
                // The counter holds in standby and restarts on a recessive bit.
                if (!tx_dom || st_r == cpf_pkg::ST_SHUTDOWN) begin
                    cnt_nxt = '0;
                end else if (mon_on) begin
                    if (cnt_r == CNT_W'(TXDT_CYC - 1)) begin
                        to_nxt = cpf_pkg::TO_FAULT;
                        cnt_nxt = '0;
                        set_v.tdt = 1'b1;
                        tdt_stat_nxt = 1'b1;
                    end else begin
                        cnt_nxt = cnt_r + CNT_W'(1);
                    end
                end
            end
            cpf_pkg::TO_FAULT: begin
                if (tdt_clear) begin
                    cnt_nxt = '0;
                    if (tx_dom || tdt_stat_r) to_nxt = cpf_pkg::TO_RETRY;
                    else to_nxt = cpf_pkg::TO_RECOVER;
                end
            end
            cpf_pkg::TO_RETRY: begin
                if (cnt_r == CNT_W'(cpf_pkg::RETRIG_CYC - 1)) begin
                    to_nxt = cpf_pkg::TO_FAULT;
                    cnt_nxt = '0;
                    set_v.tdt = 1'b1;
                end else begin
                    cnt_nxt = cnt_r + CNT_W'(1);
                end
            end
            cpf_pkg::TO_RECOVER: begin
                if (cnt_r == CNT_W'(cpf_pkg::RECOVER_CYC - 1)) begin
                    to_nxt = cpf_pkg::TO_IDLE;
                    cnt_nxt = '0;
                end else begin
                    cnt_nxt = cnt_r + CNT_W'(1);
                end
            end
            default: to_nxt = cpf_pkg::TO_IDLE;
        endcase
        // A set in the same cycle as its clear wins.
        flags_nxt = (flags_r & ~flag_clear_i) | set_v;
        irq_nxt = irq_src & (st_r != cpf_pkg::ST_SHUTDOWN);
        drv_hi_nxt = mon_on & ~listen;
        drv_lo_nxt = mon_on & ~listen & ~stat_r.lvl;
        if (st_r == cpf_pkg::ST_SHUTDOWN) mode_nxt = cpf_pkg::OP_SHUTDOWN;
        else if (st_r == cpf_pkg::ST_STANDBY) mode_nxt = cpf_pkg::OP_STANDBY;
        else if (listen) mode_nxt = cpf_pkg::OP_LISTEN;
        else if (stat_r.lvl) mode_nxt = cpf_pkg::OP_PSEUDO;
        else mode_nxt = cpf_pkg::OP_NORMAL;
    end

    // Registers of the fault and mode logic.
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= cpf_pkg::ST_SHUTDOWN;
            to_r <= cpf_pkg::TO_IDLE;
            cnt_r <= '0;
            stat_r <= cpf_pkg::VOLT_RST;
            tdt_stat_r <= 1'b0;
            flags_r <= cpf_pkg::FLAGS_RST;
            irq_r <= 1'b0;
            drv_hi_r <= 1'b0;
            drv_lo_r <= 1'b0;
            mode_r <= cpf_pkg::OP_SHUTDOWN;
        end else begin
            st_r <= st_nxt;
            to_r <= to_nxt;
            cnt_r <= cnt_nxt;
            stat_r <= stat_nxt;
            tdt_stat_r <= tdt_stat_nxt;
            flags_r <= flags_nxt;
            irq_r <= irq_nxt;
            drv_hi_r <= drv_hi_nxt;
            drv_lo_r <= drv_lo_nxt;
            mode_r <= mode_nxt;
        end
    end

    // Wake-up event detector and pulse filter state.
    cpf_pkg::cpf_wake_type wk_r, wk_nxt;
    logic [WK_W-1:0] pc_r, pc_nxt;
    logic [1:0] ev_r, ev_nxt;
    logic rx_r, rx_nxt;
    logic stop_act;
    assign stop_act = stop_mode_i & (st_r != cpf_pkg::ST_SHUTDOWN);

    // An event is a long dominant phase followed by a long recessive one.
    always_comb begin
        wk_nxt = wk_r;
        pc_nxt = pc_r;
        ev_nxt = ev_r;
        case (wk_r)
            cpf_pkg::WK_IDLE: begin
                pc_nxt = '0;
                if (!rx_now) wk_nxt = cpf_pkg::WK_DOM;
            end
            cpf_pkg::WK_DOM: begin
                if (rx_now) begin
                    pc_nxt = '0;
                    if (pc_r >= WK_W'(cpf_pkg::WAKE_PULSE_CYC)) wk_nxt = cpf_pkg::WK_REC;
                    else wk_nxt = cpf_pkg::WK_IDLE;
                end else if (pc_r != WK_W'(cpf_pkg::WAKE_PULSE_CYC)) begin
                    pc_nxt = pc_r + WK_W'(1);
                end
            end
            cpf_pkg::WK_REC: begin
                if (!rx_now) begin
                    wk_nxt = cpf_pkg::WK_DOM;
                    pc_nxt = '0;
                end else if (pc_r == WK_W'(cpf_pkg::WAKE_PULSE_CYC - 1)) begin
                    wk_nxt = cpf_pkg::WK_IDLE;
                    if (ev_r != 2'h2) ev_nxt = ev_r + 2'h1;
                end else begin
                    pc_nxt = pc_r + WK_W'(1);
                end
            end
            default: wk_nxt = cpf_pkg::WK_IDLE;
        endcase
        // Counting starts only at stop entry, so early events are not masked.
        if (!stop_act) begin
            wk_nxt = cpf_pkg::WK_IDLE;
            ev_nxt = 2'h0;
        end
        if (st_r == cpf_pkg::ST_SHUTDOWN) begin
            rx_nxt = cpf_pkg::RX_RECESSIVE;
        end else if (stop_act) begin
            if (wake_filter_select_i == cpf_pkg::WAKE_OFF) rx_nxt = cpf_pkg::RX_RECESSIVE;
            else if (ev_r >= mask_count(wake_filter_select_i)) rx_nxt = rx_now;
            else rx_nxt = cpf_pkg::RX_RECESSIVE;
        end else begin
            rx_nxt = rx_now;
        end
    end

    // Registers of the wake-up filter.
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            wk_r <= cpf_pkg::WK_IDLE;
            pc_r <= '0;
            ev_r <= 2'h0;
            rx_r <= cpf_pkg::RX_RECESSIVE;
        end else begin
            wk_r <= wk_nxt;
            pc_r <= pc_nxt;
            ev_r <= ev_nxt;
            rx_r <= rx_nxt;
        end
    end

    // Outputs come straight from flops.
    assign phy_rx_out_o = rx_r;
    assign phy_irq_out_o = irq_r;
    assign flags_o = flags_r;
    assign status_o = stat_r;
    assign tx_dominant_timeout_status_o = tdt_stat_r;
    assign drive_hi_en_o = drv_hi_r;
    assign drive_lo_en_o = drv_lo_r;
    assign mode_o = mode_r;

    // Checks on the design's own outputs.
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n);

    sequence to_expire;
        to_r == cpf_pkg::TO_IDLE && mon_on && tx_dom && cnt_r == CNT_W'(TXDT_CYC - 1);
    endsequence
    sequence clear_bad;
        to_r == cpf_pkg::TO_FAULT && tdt_clear && (tx_dom || tdt_stat_r);
    endsequence
    sequence clear_good;
        to_r == cpf_pkg::TO_FAULT && tdt_clear && !tx_dom && !tdt_stat_r;
    endsequence

    chk_irq_source: assert property (phy_irq_out_o |-> $past(irq_src))
        else $error("Interrupt without enabled flag.");
    chk_volt_gate: assert property (st_r != cpf_pkg::ST_SHUTDOWN && irq_enable_i.volt_fail
        && flags_r.lvl |=> phy_irq_out_o) else $error("Voltage flag not raising interrupt.");
    chk_to_gate: assert property (st_r != cpf_pkg::ST_SHUTDOWN && irq_enable_i.timeout
        && flags_r.tdt |=> phy_irq_out_o) else $error("Timeout flag not raising interrupt.");
    chk_oc_gate: assert property (st_r != cpf_pkg::ST_SHUTDOWN && irq_enable_i.overcurrent
        && flags_r.hoc |=> phy_irq_out_o) else $error("Over-current flag not raising interrupt.");
    chk_volt_flag: assert property (mon_on && volt_now.hvh != stat_r.hvh
        |=> flags_r.hvh && stat_r.hvh == $past(volt_now.hvh)) else $error("Status change lost.");
    chk_to_expire: assert property (to_expire |=> flags_r.tdt && tdt_stat_r
        ##1 !drv_hi_r && !drv_lo_r) else $error("Timeout did not release the bus.");
    chk_to_retrig: assert property (clear_bad |=> !drv_hi_r throughout
        (##[1:RETRIG_D] flags_r.tdt)) else $error("Timeout flag not set again.");
    chk_to_recover: assert property (clear_good |-> ##[1:REC_HI] (drv_hi_r || !mon_on
        || stat_r.hvh || stat_r.lvh || flags_r.hoc || flags_r.loc))
        else $error("No return to normal after clear.");
    chk_listen_off: assert property (stat_r.hvh || flags_r.loc
        |=> !drv_hi_r && !drv_lo_r) else $error("Transmitter on during listen-only.");
    chk_pseudo: assert property (mon_on && !listen && stat_r.lvl
        |=> drv_hi_r && !drv_lo_r) else $error("Pseudo-normal drivers wrong.");
    chk_oc_cause: assert property ($rose(flags_r.hoc) |-> $past(tx_dom && drv_hi_r))
        else $error("Over-current flagged while not driving.");
    chk_wake_mask: assert property (stop_act && ev_r < mask_count(wake_filter_select_i)
        |=> phy_rx_out_o) else $error("Masked wake event passed.");
    chk_shutdown: assert property (st_r != cpf_pkg::ST_SHUTDOWN
        |=> st_r != cpf_pkg::ST_SHUTDOWN) else $error("Shutdown re-entered.");

endmodule

// ===== test/cpf_ctrl_model.sv
`timescale 1ns/10ps
// Behavioural protocol controller: sends dominant on request and recovers a timeout.
module cpf_ctrl_model (
    // Clock.
    input wire logic ref_clk_i,
    // Bench requests.
    input wire logic dominant_req_i,
    input wire logic recover_en_i,
    // Transceiver status.
    input wire logic timeout_flag_i,
    input wire logic timeout_status_i,
    // Controller outputs.
    output logic phy_tx_in_o,
    output logic timeout_clear_o,
    output logic stuck_o
);
    int wait_n;

    // Acts on the rising edge with non-blocking updates, so the bench never races it.
    initial begin
        phy_tx_in_o = 1'b1;
        timeout_clear_o = 1'b0;
        stuck_o = 1'b0;
        forever begin
            @(posedge ref_clk_i);
            if (recover_en_i && timeout_flag_i === 1'b1) begin
                // Release the line first, then poll the status for no more than 3 us.
                phy_tx_in_o <= 1'b1;
                wait_n = 0;
                while (timeout_status_i !== 1'b0 && wait_n < 60) begin
                    @(posedge ref_clk_i);
                    wait_n++;
                end
                stuck_o <= (wait_n >= 60);
                timeout_clear_o <= 1'b1;
                @(posedge ref_clk_i);
                timeout_clear_o <= 1'b0;
                // Stay recessive at least 2 us before the next frame.
                repeat (40) @(posedge ref_clk_i);
            end else begin
                phy_tx_in_o <= ~dominant_req_i;
            end
        end
    end
endmodule

// ===== test/cpf_top_tb.sv
`timescale 1ns/10ps
// Self-checking bench for the transceiver fault and interrupt control.
module cpf_top_tb;
    localparam int TDC = 16;
    logic clk, rstn, en, reduced_performance_mode, stop, hoc, loc, bus, tx, rx, irq, tdts, dh, dl;
    logic dreq, ren, mclr, stuck;
    logic [1:0] sel;
    cpf_pkg::cpf_irq_en_type ien;
    cpf_pkg::cpf_flags_type bclr, clr, fl;
    cpf_pkg::cpf_volt_type vc, st;
    cpf_pkg::cpf_mode_type mode;
    int miscompares = 0;
    int samples_checked = 0;
    int n;

    // Bench and controller clears share the write-one-to-clear port.
    assign clr = bclr | {4'h0, mclr, 2'h0};

    cpf_top #(.TXDT_CYC(TDC)) uut (.ref_clk_i(clk), .rstn_i(rstn), .phy_enable_i(en),
        .reduced_performance_mode_i(reduced_performance_mode), .stop_mode_i(stop), .wake_filter_select_i(sel),
        .irq_enable_i(ien), .flag_clear_i(clr), .volt_cmp_i(vc), .hi_oc_cmp_i(hoc),
        .lo_oc_cmp_i(loc), .bus_rx_i(bus), .phy_tx_in_i(tx), .phy_rx_out_o(rx),
        .phy_irq_out_o(irq), .flags_o(fl), .status_o(st), .tx_dominant_timeout_status_o(tdts),
        .drive_hi_en_o(dh), .drive_lo_en_o(dl), .mode_o(mode));

    cpf_ctrl_model ctrl (.ref_clk_i(clk), .dominant_req_i(dreq), .recover_en_i(ren),
        .timeout_flag_i(fl.tdt), .timeout_status_i(tdts), .phy_tx_in_o(tx),
        .timeout_clear_o(mclr), .stuck_o(stuck));

    // Free-running 20 MHz clock.
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic chk(input logic ok, input string m);
        samples_checked++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("ERROR %0t %s", $time, m);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask

    // A wait that used up its bound ends the run at once.
    task automatic lim(input int k, input int m);
        if (k >= m) begin
            miscompares++;
            $display("ERROR %0t wait limit reached", $time);
            final_report();
        end
    endtask

    task automatic wclr(input cpf_pkg::cpf_flags_type f);
        bclr = f;
        cyc(1);
        bclr = 7'h00;
    endtask

    task automatic final_report();
        $display("mismatches %0d checks %0d", miscompares, samples_checked);
        if (miscompares == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic t_reset();
        chk(mode === cpf_pkg::OP_SHUTDOWN && rx === 1'b1 && dh === 1'b0, "reset state");
        vc = 4'h8;
        cyc(8);
        chk(fl === 7'h00 && irq === 1'b0 && st === 4'h0, "shutdown monitors");
        vc = 4'h0;
        ien = 3'h7;
        cyc(4);
        en = 1'b1;
        cyc(4);
        chk(mode === cpf_pkg::OP_NORMAL && dh === 1'b1 && dl === 1'b1, "normal entry");
        en = 1'b0;
        cyc(4);
        chk(mode === cpf_pkg::OP_NORMAL, "no shutdown re-entry");
    endtask

    task automatic t_volt();
        logic [3:0] v;
        ien = 3'h4;
        for (int i = 0; i < 4; i++) begin
            v = 4'h8 >> i;
            vc = v;
            cyc(6);
            chk(st === v && fl === {v, 3'h0} && irq === 1'b1, "volt set");
            chk(dh === i[0] && dl === (i == 1), "volt drivers");
            chk(mode === (i[0] ? (i == 1 ? cpf_pkg::OP_NORMAL : cpf_pkg::OP_PSEUDO)
                : cpf_pkg::OP_LISTEN), "volt mode");
            vc = 4'h0;
            cyc(6);
            chk(st === 4'h0 && fl === {v, 3'h0} && dh === 1'b1 && dl === 1'b1, "gone");
            chk(mode === cpf_pkg::OP_NORMAL, "auto return");
            wclr(7'h00);
            chk(fl === {v, 3'h0}, "zero write");
            ien = 3'h0;
            cyc(2);
            chk(irq === 1'b0, "volt gated");
            ien = 3'h4;
            wclr({v, 3'h0});
            cyc(2);
            chk(fl === 7'h00 && irq === 1'b0, "volt cleared");
        end
    endtask

    task automatic t_oc();
        ien = 3'h1;
        for (int i = 0; i < 2; i++) begin
            hoc = (i == 0);
            loc = (i == 1);
            cyc(6);
            chk(fl === 7'h00, "oc while recessive");
            dreq = 1'b1;
            cyc(6);
            dreq = 1'b0;
            chk(fl === (7'h02 >> i) && dh === 1'b0 && dl === 1'b0 && irq === 1'b1, "oc");
            chk(mode === cpf_pkg::OP_LISTEN, "oc listen");
            hoc = 1'b0;
            loc = 1'b0;
            cyc(8);
            chk(dh === 1'b0 && dl === 1'b0, "oc latched");
            wclr(7'h02 >> i);
            cyc(3);
            chk(fl === 7'h00 && dh === 1'b1 && irq === 1'b0, "oc cleared");
        end
    endtask

    task automatic t_tdt();
        ien = 3'h2;
        dreq = 1'b1;
        for (n = 0; n < 60 && fl.tdt !== 1'b1; n++) cyc(1);
        lim(n, 60);
        chk(n >= TDC && tdts === 1'b1, "timeout set");
        cyc(2);
        chk(mode === cpf_pkg::OP_LISTEN && dh === 1'b0 && dl === 1'b0 && irq === 1'b1,
            "released");
        ien = 3'h0;
        cyc(2);
        chk(irq === 1'b0, "timeout gated");
        wclr(7'h04);
        chk(fl.tdt === 1'b0, "timeout cleared");
        for (n = 0; n < 200 && fl.tdt !== 1'b1; n++) cyc(1);
        lim(n, 200);
        chk(n > 20 && mode === cpf_pkg::OP_LISTEN, "retrigger");
        ren = 1'b1;
        dreq = 1'b0;
        for (n = 0; n < 200 && mclr !== 1'b1; n++) cyc(1);
        lim(n, 200);
        for (n = 0; n < 100 && dh !== 1'b1; n++) cyc(1);
        lim(n, 100);
        chk(n >= 19 && n <= 40 && stuck === 1'b0, "recovery time");
        ren = 1'b0;
        cyc(40);
    endtask

    // Out of stop the filter must not act; in stop each code masks its own count.
    task automatic t_wake();
        int m;
        sel = 2'h3;
        bus = 1'b0;
        cyc(10);
        chk(rx === 1'b0, "no filter before stop");
        bus = 1'b1;
        for (int s = 0; s < 4; s++) begin
            sel = s[1:0];
            m = (s == 0) ? 9 : (s == 2) ? 0 : (s + 1) / 2;
            cyc(2);
            stop = 1'b1;
            for (int k = 0; k < 3; k++) begin
                bus = 1'b0;
                cyc(15);
                chk(rx === (k < m), "wake filter");
                cyc(10);
                bus = 1'b1;
                cyc(25);
            end
            stop = 1'b0;
        end
    endtask

    task automatic t_stby();
        reduced_performance_mode = 1'b1;
        cyc(4);
        chk(mode === cpf_pkg::OP_STANDBY, "standby entry");
        dreq = 1'b1;
        vc = 4'h8;
        cyc(30);
        chk(fl === 7'h00 && st === 4'h0, "monitors off");
        dreq = 1'b0;
        vc = 4'h0;
        cyc(6);
        reduced_performance_mode = 1'b0;
        cyc(6);
        chk(mode === cpf_pkg::OP_NORMAL && fl === 7'h00, "standby exit");
    endtask

    // Reset for six cycles, then every scenario in turn.
    initial begin
        rstn = 1'b0;
        en = 1'b0;
        reduced_performance_mode = 1'b0;
        stop = 1'b0;
        sel = 2'h0;
        ien = 3'h0;
        bclr = 7'h00;
        vc = 4'h0;
        hoc = 1'b0;
        loc = 1'b0;
        bus = 1'b1;
        dreq = 1'b0;
        ren = 1'b0;
        cyc(6);
        rstn = 1'b1;
        cyc(5);
        t_reset();
        t_volt();
        t_oc();
        t_tdt();
        t_wake();
        t_stby();
        final_report();
    end
endmodule
